// ### can_timing_power_interrupts.sv
`include "can_timing_cfg.svh"
`default_nettype none
// Contract
// - timing write only in init
// - bit seven: majority of three
// - bits 6-4 seg two, 3-0 one
// - quantum = clock / (prescaler+1)
// - run: sleep only low-power state
// - wait, stop-in-wait: power-down
// - wait otherwise: keep operating
// - stop forces power-down
// - enable: disabled to normal
// - receive full after frame end
// - receive full again for next
// - bus activity wakes low power
// - wake needs sleep, option, enable
// - error irq on overrun or status
// - status change reports codes
// - pending while any flag set; wake only while its enable is set
// - write one clears; condition blocks
module can_timing_power_interrupts (
    input wire logic clk_sys, // clock
    input wire logic rst, // sync reset
    input wire logic [3:0] regAddr, // address
    input wire logic [7:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [7:0] regRdData, // read data
    input wire logic [1:0] cpuState, // cpu state
    input wire logic canRx, // bus pin, async
    input wire logic frameEnd, // good frame end
    input wire logic [7:0] frameData, // first frame byte
    input wire logic [7:0] txErrCount, // tx errors
    input wire logic [7:0] rxErrCount, // rx errors
    output logic rxBit, // resolved bit
    output logic samplePulse, // sample point
    output logic quantumTick, // quantum pulse
    output logic [2:0] modeState, // mode
    output logic rxIrq, // rx request
    output logic wakeIrq, // wake request
    output logic errIrq // error request
);
    // control and configuration
    logic [7:0] control_q; // control bits
    logic [7:0] bitTiming_q; // bit timing
    logic [5:0] prescale_q; // prescaler
    logic initAck_q; // init ack
    logic sleepAck_q; // sleep ack
    logic wakeIrqEn_q; // wake irq enable
    can_timing_pkg::ctrl_mode_type mode_q; // mode
    logic sleptBefore_q; // asleep at power-down
    // flags
    logic wakeFlag_q; // wake-up
    logic statusFlag_q; // status change
    logic overrunFlag_q; // overrun
    logic rxFull_q; // receive full
    can_timing_pkg::bus_state_type txState_q; // tx state
    can_timing_pkg::bus_state_type rxState_q; // rx state
    // pin synchroniser
    logic rxMeta_q; // stage one, read by stage two only
    logic rxSync_q; // stage two
    logic rxPrev_q; // for edge detect
    // bit timing engine
    logic [5:0] preCount_q; // prescaler count
    logic [4:0] quantaCount_q; // quantum index
    logic [2:0] samples_q; // last three samples
    // fifo interface
    logic fifoNotEmpty; // not empty
    logic fifoFull; // full
    logic [7:0] fifoHead; // head byte
    logic fifoPop; // pop
    logic pendingShift_q; // next head shows a cycle later

    // decoded helpers
    logic inInit; // initialization mode
    logic asleep; // sleep mode
    logic busEdge; // falling bus edge
    logic writeFlags; // flag write
    can_timing_pkg::bus_state_type txNow; // tx state now
    can_timing_pkg::bus_state_type rxNow; // rx state now

    // maps an error count onto a bus state code
    function automatic can_timing_pkg::bus_state_type stateOf(input logic [7:0] cnt,
                                                              input logic isTx);
        if (isTx && cnt == 8'hff) begin
            stateOf = can_timing_pkg::BUS_OFF;
        end else if (cnt >= `PASSIVE_LEVEL) begin
            stateOf = can_timing_pkg::BUS_ERROR;
        end else if (cnt >= `WARN_LEVEL) begin
            stateOf = can_timing_pkg::BUS_WARNING;
        end else begin
            stateOf = can_timing_pkg::BUS_OK;
        end
    endfunction : stateOf

    assign inInit = control_q[`BIT_INIT_REQUEST] && initAck_q;
    assign asleep = control_q[`BIT_SLEEP_REQUEST] && sleepAck_q;
    assign busEdge = rxPrev_q && !rxSync_q;
    assign writeFlags = regWr && (regAddr == `OFS_RX_FLAGS);
    assign txNow = stateOf(txErrCount, 1'b1);
    assign rxNow = stateOf(rxErrCount, 1'b0);

    // two-stage synchroniser for the receive pin
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxMeta_q <= 1'b1;
            rxSync_q <= 1'b1;
            rxPrev_q <= 1'b1;
        end else begin
            rxMeta_q <= canRx;
            rxSync_q <= rxMeta_q;
            rxPrev_q <= rxSync_q;
        end
    end

    // control register; acks lag requests a cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            control_q <= `RST_CONTROL;
            initAck_q <= 1'b1;
            sleepAck_q <= 1'b0;
            wakeIrqEn_q <= 1'b0;
        end else begin
            if (regWr && regAddr == `OFS_CONTROL) begin
                control_q <= regWrData;
            end
            if (regWr && regAddr == `OFS_RX_ENABLES) begin
                wakeIrqEn_q <= regWrData[`BIT_WAKEUP_IRQ_EN];
            end
            initAck_q <= control_q[`BIT_INIT_REQUEST];
            // no sleep ack while disabled or in init
            sleepAck_q <= control_q[`BIT_SLEEP_REQUEST] && !control_q[`BIT_INIT_REQUEST]
                          && mode_q != can_timing_pkg::MODE_DISABLED;
        end
    end

    // timing registers, locked outside init
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bitTiming_q <= `RST_BIT_TIMING;
            prescale_q <= `RST_PRESCALE;
        end else if (regWr && inInit) begin
            if (regAddr == `OFS_BIT_TIMING) begin
                bitTiming_q <= regWrData;
            end
            if (regAddr == `OFS_PRESCALE) begin
                prescale_q <= regWrData[5:0];
            end
        end
    end

    // operating mode against processor state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_q <= can_timing_pkg::MODE_DISABLED;
            sleptBefore_q <= 1'b0;
        end else begin
            case (mode_q)
                can_timing_pkg::MODE_DISABLED: begin
                    if (control_q[`BIT_CONTROLLER_ENABLE]) begin
                        mode_q <= can_timing_pkg::MODE_NORMAL;
                    end
                end
                can_timing_pkg::MODE_NORMAL, can_timing_pkg::MODE_SLEEP: begin
                    if (!control_q[`BIT_CONTROLLER_ENABLE]) begin
                        mode_q <= can_timing_pkg::MODE_DISABLED;
                    end else if (cpuState == can_timing_pkg::CPU_STOP) begin
                        mode_q <= can_timing_pkg::MODE_POWER_DOWN;
                        sleptBefore_q <= asleep;
                    end else if (cpuState == can_timing_pkg::CPU_WAIT
                                 && control_q[`BIT_STOP_IN_WAIT]) begin
                        mode_q <= can_timing_pkg::MODE_POWER_DOWN;
                        sleptBefore_q <= asleep;
                    end else if (asleep) begin
                        mode_q <= can_timing_pkg::MODE_SLEEP;
                    end else begin
                        mode_q <= can_timing_pkg::MODE_NORMAL;
                    end
                end
                can_timing_pkg::MODE_POWER_DOWN: begin
                    // leaving power-down restarts into normal mode
                    if (cpuState == can_timing_pkg::CPU_RUN
                        || (cpuState == can_timing_pkg::CPU_WAIT
                            && !control_q[`BIT_STOP_IN_WAIT])) begin
                        mode_q <= can_timing_pkg::MODE_NORMAL;
                    end
                end
                default: begin
                    mode_q <= can_timing_pkg::MODE_DISABLED;
                end
            endcase
        end
    end

    // quantum prescaler: divide by field plus one
    always_ff @(posedge clk_sys) begin
        if (rst || mode_q != can_timing_pkg::MODE_NORMAL) begin
            preCount_q <= 6'h00;
            quantumTick <= 1'b0;
        end else if (preCount_q >= prescale_q) begin
            preCount_q <= 6'h00;
            quantumTick <= 1'b1;
        end else begin
            preCount_q <= preCount_q + 6'h01;
            quantumTick <= 1'b0;
        end
    end

    // bit engine; sample at the end of segment one
    always_ff @(posedge clk_sys) begin
        if (rst || mode_q != can_timing_pkg::MODE_NORMAL || inInit) begin
            quantaCount_q <= 5'h00;
            samples_q <= 3'h7;
            samplePulse <= 1'b0;
            rxBit <= 1'b1;
        end else begin
            samplePulse <= 1'b0;
            if (quantumTick) begin
                samples_q <= {samples_q[1:0], rxSync_q};
                // total length 1 + (seg1+1) + (seg2+1) quanta
                if (quantaCount_q == 5'd2 + {1'b0, bitTiming_q[`SEG1_HI:`SEG1_LO]}
                                     + {2'h0, bitTiming_q[`SEG2_HI:`SEG2_LO]}) begin
                    quantaCount_q <= 5'h00;
                end else begin
                    quantaCount_q <= quantaCount_q + 5'h01;
                end
                // sample point is the last quantum of segment one
                if (quantaCount_q == 5'd1 + {1'b0, bitTiming_q[`SEG1_HI:`SEG1_LO]}) begin
                    samplePulse <= 1'b1;
                    if (bitTiming_q[`BIT_TRIPLE_SAMPLE]) begin
                        // majority of the two earlier quanta and this one
                        rxBit <= (samples_q[0] & samples_q[1]) | (samples_q[0] & rxSync_q)
                                 | (samples_q[1] & rxSync_q);
                    end else begin
                        rxBit <= rxSync_q;
                    end
                end
            end
        end
    end

    // receive fifo holding the first byte of each message
    rx_buffer_mem rxFifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(frameEnd && mode_q == can_timing_pkg::MODE_NORMAL && !inInit),
        .wrData(frameData),
        .rdEn(fifoPop),
        .rdData(fifoHead),
        .notEmpty(fifoNotEmpty),
        .full(fifoFull)
    );

    // clearing receive full pops the fifo
    assign fifoPop = writeFlags && regWrData[`BIT_RECEIVE_FULL] && rxFull_q;

    // receive full: set once a message is shown
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxFull_q <= 1'b0;
            pendingShift_q <= 1'b0;
        end else begin
            pendingShift_q <= fifoPop;
            if (!rxFull_q && !pendingShift_q && !fifoPop && fifoNotEmpty) begin
                rxFull_q <= 1'b1;
            end else if (fifoPop) begin
                rxFull_q <= 1'b0;
            end
        end
    end

    // wake-up, overrun and status-change flags; set beats clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wakeFlag_q <= 1'b0;
            overrunFlag_q <= 1'b0;
            statusFlag_q <= 1'b0;
            txState_q <= can_timing_pkg::BUS_OK;
            rxState_q <= can_timing_pkg::BUS_OK;
        end else begin
            if ((mode_q == can_timing_pkg::MODE_SLEEP
                 || (mode_q == can_timing_pkg::MODE_POWER_DOWN && sleptBefore_q))
                && control_q[`BIT_WAKEUP_OPTION] && busEdge) begin
                wakeFlag_q <= 1'b1;
            end else if (writeFlags && regWrData[`BIT_WAKEUP_FLAG]) begin
                wakeFlag_q <= 1'b0;
            end
            if (frameEnd && fifoFull) begin
                overrunFlag_q <= 1'b1;
            end else if (writeFlags && regWrData[`BIT_OVERRUN_FLAG]) begin
                overrunFlag_q <= 1'b0;
            end
            if (txNow != txState_q || rxNow != rxState_q) begin
                statusFlag_q <= 1'b1;
                txState_q <= txNow;
                rxState_q <= rxNow;
            end else if (writeFlags && regWrData[`BIT_STATUS_FLAG]) begin
                statusFlag_q <= 1'b0;
            end
        end
    end

    // requests stay high while a source flag is set; wake also needs its enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxIrq <= 1'b0;
            wakeIrq <= 1'b0;
            errIrq <= 1'b0;
        end else begin
            rxIrq <= rxFull_q;
            wakeIrq <= wakeFlag_q && wakeIrqEn_q;
            errIrq <= overrunFlag_q || statusFlag_q;
        end
    end

    // mode output and read port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            modeState <= 3'h0;
            regRdData <= 8'h00;
        end else begin
            modeState <= mode_q;
            regRdData <= 8'h00;
            if (regRd) begin
                case (regAddr)
                    `OFS_CONTROL: regRdData <= control_q;
                    `OFS_SLEEP_ACK: regRdData <= {6'h00, sleepAck_q, initAck_q};
                    `OFS_PRESCALE: regRdData <= {2'h0, prescale_q};
                    `OFS_BIT_TIMING: regRdData <= bitTiming_q;
                    `OFS_RX_FLAGS: regRdData <= {wakeFlag_q, rxState_q, txState_q,
                                                 overrunFlag_q, statusFlag_q, rxFull_q};
                    `OFS_RX_ENABLES: regRdData <= {wakeIrqEn_q, 7'h00};
                    `OFS_BIT_COUNT: regRdData <= {3'h0, quantaCount_q};
                    `OFS_RX_BUFFER: regRdData <= fifoHead;
                    default: regRdData <= 8'h00;
                endcase
            end
        end
    end
endmodule : can_timing_power_interrupts
`default_nettype wire

// ### can_timing_cfg.svh
`ifndef CAN_TIMING_CFG_SVH
`define CAN_TIMING_CFG_SVH

// register offsets
`define OFS_CONTROL 4'h0
`define OFS_SLEEP_ACK 4'h1
`define OFS_PRESCALE 4'h2
`define OFS_BIT_TIMING 4'h3
`define OFS_RX_FLAGS 4'h4
`define OFS_RX_ENABLES 4'h5
`define OFS_BIT_COUNT 4'h6
`define OFS_RX_BUFFER 4'h7

// control bits
`define BIT_INIT_REQUEST 0
`define BIT_SLEEP_REQUEST 1
`define BIT_STOP_IN_WAIT 2
`define BIT_WAKEUP_OPTION 3
`define BIT_CONTROLLER_ENABLE 7

// timing fields
`define BIT_TRIPLE_SAMPLE 7
`define SEG2_HI 6
`define SEG2_LO 4
`define SEG1_HI 3
`define SEG1_LO 0

// flag and enable bits
`define BIT_WAKEUP_FLAG 7
`define BIT_STATUS_FLAG 1
`define BIT_RECEIVE_FULL 0
`define BIT_OVERRUN_FLAG 2
`define BIT_WAKEUP_IRQ_EN 7

// reset values
`define RST_BIT_TIMING 8'h00
`define RST_CONTROL 8'h01
`define RST_PRESCALE 6'h00

// error levels
`define WARN_LEVEL 8'h60
`define PASSIVE_LEVEL 8'h80

`endif

// ### can_timing_pkg.sv
`default_nettype none
package can_timing_pkg;
    // operating mode of the controller
    typedef enum logic [2:0] {
        MODE_DISABLED = 3'b000,
        MODE_NORMAL = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_POWER_DOWN = 3'b011
    } ctrl_mode_type;

    // processor power state as seen by the controller
    typedef enum logic [1:0] {
        CPU_RUN = 2'b00,
        CPU_WAIT = 2'b01,
        CPU_STOP = 2'b10
    } cpu_state_type;

    // bus state code reported for each error counter
    typedef enum logic [1:0] {
        BUS_OK = 2'b00,
        BUS_WARNING = 2'b01,
        BUS_ERROR = 2'b10,
        BUS_OFF = 2'b11
    } bus_state_type;
endpackage : can_timing_pkg
`default_nettype wire

// ### rx_buffer_mem.sv
`default_nettype none
// small receive FIFO; read data comes out of a register
module rx_buffer_mem (
    input wire logic clk_sys, // system clock
    input wire logic rst, // synchronous reset
    input wire logic wrEn, // push
    input wire logic [7:0] wrData, // push word
    input wire logic rdEn, // pop
    output logic [7:0] rdData, // head, registered
    output logic notEmpty, // not empty
    output logic full // full
);
    logic [7:0] mem [0:3]; // storage words
    logic [1:0] wrPtr_q; // write pointer
    logic [1:0] rdPtr_q; // read pointer
    logic [2:0] count_q; // words held

    // storage write and registered head read
    always_ff @(posedge clk_sys) begin
        if (wrEn && !full) begin
            mem[wrPtr_q] <= wrData;
        end
        rdData <= mem[rdPtr_q];
    end

    // pointers and fill count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr_q <= 2'h0;
            rdPtr_q <= 2'h0;
            count_q <= 3'h0;
        end else begin
            if (wrEn && !full) begin
                wrPtr_q <= wrPtr_q + 2'h1;
            end
            if (rdEn && notEmpty) begin
                rdPtr_q <= rdPtr_q + 2'h1;
            end
            count_q <= count_q + {2'h0, (wrEn && !full)} - {2'h0, (rdEn && notEmpty)};
        end
    end

    assign notEmpty = (count_q != 3'h0);
    assign full = (count_q == 3'h4);
endmodule : rx_buffer_mem
`default_nettype wire

// ### can_timing_power_interrupts_props.sv
`default_nettype none
// checker on the top ports, one clock domain
module can_timing_power_interrupts_chk (
    input wire logic clk_sys, // clock
    input wire logic rst, // sync reset
    input wire logic [3:0] regAddr, // address
    input wire logic [7:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [7:0] regRdData, // read data
    input wire logic [1:0] cpuState, // cpu state
    input wire logic [2:0] modeState, // mode
    input wire logic quantumTick, // quantum pulse
    input wire logic samplePulse, // sample pulse
    input wire logic rxIrq, // rx request
    input wire logic wakeIrq, // wake request
    input wire logic errIrq // error request
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic [1:0] rxClr_q; // rx full clears
    logic [1:0] errClr_q; // status or overrun clears
    logic [1:0] wakeClr_q; // wake clear or enable writes
    logic [2:0] enWr_q; // enable writes; mode shows them three edges on
    // short history, so a request drop can be traced to its write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxClr_q <= 2'h0;
            errClr_q <= 2'h0;
            wakeClr_q <= 2'h0;
            enWr_q <= 3'h0;
        end else begin
            rxClr_q <= {rxClr_q[0], regWr && regAddr == 4'h4 && regWrData[0]};
            errClr_q <= {errClr_q[0], regWr && regAddr == 4'h4 && |regWrData[2:1]};
            wakeClr_q <= {wakeClr_q[0], regWr && regAddr[3:1] == 3'h2};
            enWr_q <= {enWr_q[1:0], regWr && regAddr == 4'h0 && regWrData[7]};
        end
    end
    read_idle_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside the answer cycle");
    stop_powerdown_a: assert property ((cpuState == 2'h2)[*3]
        |-> modeState inside {3'h3, 3'h0})
        else $error("stop without power-down");
    run_no_powerdown_a: assert property ((cpuState == 2'h0)[*3]
        |-> modeState != 3'h3)
        else $error("power-down while running");
    idle_no_tick_a: assert property ((modeState == 3'h0)[*2]
        |-> !quantumTick && !samplePulse)
        else $error("timing runs while disabled");
    sample_spacing_a: assert property (samplePulse |=> (!samplePulse)[*2])
        else $error("bit shorter than three quanta");
    rx_clear_only_a: assert property ($fell(rxIrq) |-> |rxClr_q)
        else $error("receive request dropped without a clear");
    err_clear_only_a: assert property ($fell(errIrq) |-> |errClr_q)
        else $error("error request dropped without a clear");
    wake_clear_only_a: assert property ($fell(wakeIrq) |-> |wakeClr_q)
        else $error("wake request dropped without a write");
    enable_to_normal_a: assert property ($past(modeState) == 3'h0 && modeState != 3'h0
        |-> |enWr_q)
        else $error("left disabled without enable write");
endmodule : can_timing_power_interrupts_chk

bind can_timing_power_interrupts can_timing_power_interrupts_chk chk (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cpuState(cpuState),
    .modeState(modeState), .quantumTick(quantumTick), .samplePulse(samplePulse),
    .rxIrq(rxIrq), .wakeIrq(wakeIrq), .errIrq(errIrq)
);
`default_nettype wire

// ### can_bus_node.sv
`default_nettype none
// other node on the bus: drives the pin and hands over good frames
module can_bus_node (
    input wire logic clk_sys, // system clock
    output logic canRx, // bus level, recessive high
    output logic frameEnd, // good frame finished
    output logic [7:0] frameData // first byte of that frame
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus idles recessive
    initial begin
        canRx = 1'h1;
        frameEnd = 1'h0;
        frameData = 8'h00;
    end
    // one finished frame; the byte is scrambled afterwards, never left stale
    task automatic send_frame(input logic [7:0] data);
        @(posedge clk_sys);
        frameEnd <= 1'h1;
        frameData <= data;
        @(posedge clk_sys);
        frameEnd <= 1'h0;
        frameData <= ~data;
    endtask : send_frame
    // dominant level for a number of clocks, then back to recessive
    task automatic drive_low(input int cycles);
        @(posedge clk_sys);
        canRx <= 1'h0;
        repeat (cycles) @(posedge clk_sys);
        canRx <= 1'h1;
    endtask : drive_low
endmodule : can_bus_node
`default_nettype wire

// ### tb_can_timing_power_interrupts.sv
`default_nettype none
module tb_can_timing_power_interrupts;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, regWr, regRd, canRx, frameEnd; // stimulus
    logic rxBit, samplePulse, quantumTick, rxIrq, wakeIrq, errIrq; // outputs
    logic [3:0] regAddr; // address
    logic [7:0] regWrData, regRdData, frameData, txErrCount, rxErrCount; // data
    logic [1:0] cpuState; // cpu
    logic [2:0] modeState; // mode
    int miscompares = 0, checkCount = 0, cycles = 0, gap = 0; // counters

    can_timing_power_interrupts uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .cpuState(cpuState), .canRx(canRx), .frameEnd(frameEnd), .frameData(frameData),
        .txErrCount(txErrCount), .rxErrCount(rxErrCount), .rxBit(rxBit),
        .samplePulse(samplePulse), .quantumTick(quantumTick), .modeState(modeState),
        .rxIrq(rxIrq), .wakeIrq(wakeIrq), .errIrq(errIrq));
    can_bus_node node (.clk_sys(clk_sys), .canRx(canRx), .frameEnd(frameEnd),
        .frameData(frameData));

    // 40 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("ERROR timeout expected done seen running");
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checkCount++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_byte(n, {7'h00, e}, {7'h00, g});
    endtask : chk_bit
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'h0;
    endtask : wr
    // one-cycle read strobe; data stands only in the following cycle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge clk_sys);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'h0;
        #1;
        chk_byte(n, e, regRdData);
    endtask : rd_chk
    // latencies are three cycles at most
    task automatic settle();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : settle
    task automatic wrs(input logic [3:0] a, input logic [7:0] d);
        wr(a, d);
        settle();
    endtask : wrs
    task automatic chk_mode(input logic [2:0] e);
        chk_byte("mode", {5'h00, e}, {5'h00, modeState});
    endtask : chk_mode
    // counts clocks to the next sample point, bounded
    task automatic next_sample(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (samplePulse !== 1'h1 && n < 200);
    endtask : next_sample
    task automatic set_cpu(input logic [1:0] s);
        @(posedge clk_sys);
        cpuState <= s;
        settle();
    endtask : set_cpu

    initial begin
        rst = 1'h1;
        {regWr, regRd, regAddr, regWrData, cpuState} = '0;
        rxErrCount = 8'h00;
        txErrCount = rxErrCount;
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        // reset values, unmapped address
        rd_chk(4'h0, 8'h01, "control");
        rd_chk(4'h1, 8'h01, "ack");
        rd_chk(4'h3, 8'h00, "bitTiming");
        rd_chk(4'hf, 8'h00, "unmapped");
        chk_mode(3'h0);
        // enable in init; triple sample, seg1 of 4 quanta
        wrs(4'h0, 8'h81);
        chk_mode(3'h1);
        wr(4'h2, 8'h01);
        wr(4'h3, 8'ha3);
        rd_chk(4'h3, 8'ha3, "bitTiming");
        rd_chk(4'h2, 8'h01, "prescale");
        // outside init the timing write is refused
        wrs(4'h0, 8'h80);
        rd_chk(4'h1, 8'h00, "ack");
        wr(4'h3, 8'h55);
        rd_chk(4'h3, 8'ha3, "bitTiming");
        // 8 quanta of 2 clocks per bit
        next_sample(gap);
        next_sample(gap);
        chk_byte("bitClocks", 8'h10, gap[7:0]);
        node.drive_low(40);
        @(posedge clk_sys);
        #1;
        chk_bit("rxBit", 1'h0, rxBit);
        repeat (40) @(posedge clk_sys);
        #1;
        chk_bit("rxBit", 1'h1, rxBit);
        // two frames queue; the second follows the first clear
        node.send_frame(8'ha5);
        node.send_frame(8'h3c);
        settle();
        rd_chk(4'h4, 8'h01, "flags");
        chk_bit("rxIrq", 1'h1, rxIrq);
        rd_chk(4'h7, 8'ha5, "rxByte");
        wrs(4'h4, 8'h00);
        chk_bit("rxIrq", 1'h1, rxIrq);
        wrs(4'h4, 8'h01);
        chk_bit("rxIrq", 1'h1, rxIrq);
        rd_chk(4'h7, 8'h3c, "rxByte");
        wrs(4'h4, 8'h01);
        chk_bit("rxIrq", 1'h0, rxIrq);
        // fifo of four, fifth frame overruns
        for (int i = 0; i < 5; i++) node.send_frame(8'h10 + 8'(i));
        settle();
        rd_chk(4'h4, 8'h05, "flags");
        chk_bit("errIrq", 1'h1, errIrq);
        wrs(4'h4, 8'h04);
        chk_bit("errIrq", 1'h0, errIrq);
        rd_chk(4'h4, 8'h01, "flags");
        rd_chk(4'h7, 8'h10, "rxByte");
        // a clear lands only once the next message is shown
        repeat (4) wrs(4'h4, 8'h01);
        chk_bit("rxIrq", 1'h0, rxIrq);
        // error counters: warning, error, bus-off
        txErrCount <= 8'h60;
        settle();
        rd_chk(4'h4, 8'h0a, "flags");
        chk_bit("errIrq", 1'h1, errIrq);
        wrs(4'h4, 8'h02);
        rd_chk(4'h4, 8'h08, "flags");
        rxErrCount <= 8'h80;
        settle();
        rd_chk(4'h4, 8'h4a, "flags");
        txErrCount <= 8'hff;
        settle();
        rd_chk(4'h4, 8'h5a, "flags");
        {txErrCount, rxErrCount} <= 16'h0000;
        settle();
        wrs(4'h4, 8'h02);
        chk_bit("errIrq", 1'h0, errIrq);
        // power modes against processor states
        wrs(4'h0, 8'h82);
        chk_mode(3'h2);
        rd_chk(4'h1, 8'h02, "ack");
        set_cpu(2'h1);
        chk_mode(3'h2);
        wrs(4'h0, 8'h80);
        chk_mode(3'h1);
        node.send_frame(8'h5a);
        settle();
        chk_bit("rxIrq", 1'h1, rxIrq);
        wr(4'h4, 8'h01);
        wrs(4'h0, 8'h84);
        chk_mode(3'h3);
        set_cpu(2'h0);
        chk_mode(3'h1);
        set_cpu(2'h2);
        chk_mode(3'h3);
        set_cpu(2'h0);
        // wake from sleep, masked wake, wake from power-down
        wr(4'h5, 8'h80);
        wrs(4'h0, 8'h8a);
        chk_mode(3'h2);
        node.drive_low(8);
        settle();
        chk_bit("wakeIrq", 1'h1, wakeIrq);
        rd_chk(4'h4, 8'h80, "flags");
        wrs(4'h4, 8'h80);
        chk_bit("wakeIrq", 1'h0, wakeIrq);
        wr(4'h5, 8'h00);
        node.drive_low(8);
        settle();
        chk_bit("wakeIrq", 1'h0, wakeIrq);
        wr(4'h4, 8'h80);
        wr(4'h5, 8'h80);
        set_cpu(2'h2);
        chk_mode(3'h3);
        node.drive_low(8);
        settle();
        chk_bit("wakeIrq", 1'h1, wakeIrq);
        set_cpu(2'h0);
        wrs(4'h4, 8'h80);
        chk_bit("wakeIrq", 1'h0, wakeIrq);
        tally_and_finish();
    end
endmodule : tb_can_timing_power_interrupts
`default_nettype wire
